// ==== rtl/beat_if.sv ====
`timescale 1ns/100ps
interface beat_if #(parameter int DATA_W = 32, parameter int EMPTY_W = 2);
	logic               valid;
	logic [DATA_W-1:0]  data;
	logic               first;
	logic               last;
	logic [EMPTY_W-1:0] empty;
	logic [DATA_W-1:0]  mask;
	modport producer (output valid, output data, output first, output last, output empty,
		input mask);
	modport consumer (input valid, input data, input first, input last, input empty,
		output mask);
endinterface

// ==== rtl/empty_mask.sv ====
`timescale 1ns/100ps
module empty_mask
	import stream_pkg::*;
#(
	parameter int SYMBOLS  = 4,
	parameter int SYMBOL_W = 8,
	parameter int EMPTY_W  = 2
)(
	beat_if.consumer bt,
	input  wire logic msb_first
);
	// marks symbols that hold data; trailing ones are empty
	always_comb
	begin
		bt.mask = '0;
		for (int i = 0; i < SYMBOLS; i++)
		begin
			logic [31:0] pos;
			pos = msb_first ? 32'(SYMBOLS - 1 - i) : 32'(i);
			if (!(bt.valid && bt.last) || pos < 32'(SYMBOLS) - 32'(bt.empty))
				bt.mask[i*SYMBOL_W +: SYMBOL_W] = {SYMBOL_W{1'b1}};
		end
	end
endmodule // empty_mask

// ==== rtl/stream_pkg.sv ====
package stream_pkg;
	localparam int DATA_W_DEF        = 32;
	localparam int SYMBOL_W_DEF      = 8;
	localparam int READY_DELAY_DEF   = 0;
	localparam int CAPACITY_UNSET    = -1;
	localparam int DEPTH_DEF         = 4;
	localparam logic [1:0] REG_CTRL  = 2'h0;
	localparam logic [1:0] REG_STAT  = 2'h1;
	localparam logic [1:0] REG_BEAT  = 2'h2;
	localparam logic [1:0] REG_COUNT = 2'h3;
	localparam int CTRL_ACCEPT_BIT   = 0;
	localparam int CTRL_MSB_BIT      = 1;
	localparam int CTRL_POP_BIT      = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
	typedef enum logic [1:0] {
		PKT_IDLE = 2'b00,
		PKT_BODY = 2'b01,
		PKT_ERR  = 2'b11
	} pkt_state_t;
endpackage

// ==== rtl/stream_sink.sv ====
`timescale 1ns/100ps
module stream_sink
	import stream_pkg::*;
#(
	parameter int DATA_W      = DATA_W_DEF,
	parameter int SYMBOL_W    = SYMBOL_W_DEF,
	parameter int READY_DELAY = READY_DELAY_DEF,
	parameter int CAPACITY    = CAPACITY_UNSET,
	parameter int DEPTH       = DEPTH_DEF
)(
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              clk_en,
	input  wire logic              in_valid,
	input  wire logic [DATA_W-1:0] in_data,
	input  wire logic              in_first,
	input  wire logic              in_last,
	input  wire logic [$clog2(DATA_W/SYMBOL_W)>0?$clog2(DATA_W/SYMBOL_W)-1:0:0] in_empty,
	output logic                   in_ready,
	input  wire logic [1:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic [31:0]            reg_rdata
);
	localparam int SYMBOLS = DATA_W / SYMBOL_W;
	localparam int EMPTY_W = (SYMBOLS > 1) ? $clog2(SYMBOLS) : 1;
	localparam int CAP     = (CAPACITY < 0) ? READY_DELAY : CAPACITY;
	localparam int HIST    = (READY_DELAY > 0) ? READY_DELAY : 1;
	localparam int CNT_W   = $clog2(DEPTH + 1);

	// ************************************************************
	// reset release
	// ************************************************************
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [31:0]                 ctrl;
		logic [HIST-1:0]             ready_hist;
		logic [DEPTH-1:0][DATA_W+1:0] store;
		logic [CNT_W-1:0]            fill;
		pkt_state_t                  pkt;
		logic [15:0]                 packets;
		logic [15:0]                 beats;
		logic                        overrun;
		logic                        framing_err;
		logic [31:0]                 rdata;
	} state_t;

	state_t st_reg;
	state_t st_next;

	beat_if #(.DATA_W(DATA_W), .EMPTY_W(EMPTY_W)) bt ();

	assign bt.valid = in_valid;
	assign bt.data  = in_data;
	assign bt.first = in_first;
	assign bt.last  = in_last;
	assign bt.empty = EMPTY_W'(in_empty);

	empty_mask #(
		.SYMBOLS  (SYMBOLS),
		.SYMBOL_W (SYMBOL_W),
		.EMPTY_W  (EMPTY_W)
	) u_mask (
		.bt        (bt),
		.msb_first (st_reg.ctrl[CTRL_MSB_BIT])
	);

	// ready: room for capacity beats still in flight after a drop
	logic ready_now;
	logic ready_cycle;
	logic take;
	logic pop;
	always_comb
	begin
		// held low until the released reset copy is high
		ready_now = rst_n && st_reg.ctrl[CTRL_ACCEPT_BIT] &&
			(32'(st_reg.fill) + 32'(CAP) < 32'(DEPTH));
		ready_cycle = (READY_DELAY == 0) ? 1'b1 : st_reg.ready_hist[HIST-1];
	end
	assign in_ready = ready_now;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		st_next = st_reg;
		st_next.rdata = 32'h0000_0000;
		if (READY_DELAY == 0)
			take = in_valid && (ready_now || CAP > 0) && (32'(st_reg.fill) < 32'(DEPTH));
		else
			take = in_valid && ready_cycle && (32'(st_reg.fill) < 32'(DEPTH));
		pop = reg_write && reg_addr == REG_CTRL && reg_wdata[CTRL_POP_BIT] && st_reg.fill != '0;
		if (READY_DELAY > 0)
			st_next.ready_hist = HIST'({st_reg.ready_hist, ready_now});
		// a valid beat outside allowance is dropped and flagged
		if (in_valid && !take)
			st_next.overrun = 1'b1;
		if (pop)
		begin
			for (int i = 0; i < DEPTH - 1; i++)
				st_next.store[i] = st_reg.store[i+1];
			st_next.fill = st_reg.fill - CNT_W'(1);
		end
		if (take)
		begin
			// markers stored alongside masked data
			st_next.store[st_next.fill] = {in_first, in_last, in_data & bt.mask};
			st_next.fill = st_next.fill + CNT_W'(1);
			st_next.beats = st_reg.beats + 16'h0001;
			// packet tracking; markers only looked at on active beats
			case (st_reg.pkt)
				PKT_IDLE, PKT_ERR:
				begin
					if (!in_first)
						st_next.framing_err = 1'b1;
					else if (!in_last)
						st_next.pkt = PKT_BODY;
					else
						st_next.packets = st_reg.packets + 16'h0001;
				end
				PKT_BODY:
				begin
					if (in_first)
						st_next.framing_err = 1'b1;
					if (in_last)
					begin
						st_next.pkt = PKT_IDLE;
						st_next.packets = st_reg.packets + 16'h0001;
					end
				end
				default:
					st_next.pkt = PKT_IDLE;
			endcase
		end
		// register writes; status flags cleared by writing one, set wins
		if (reg_write)
		begin
			if (reg_addr == REG_CTRL)
				st_next.ctrl = {29'h0, 1'b0, reg_wdata[CTRL_MSB_BIT:0]};
			else if (reg_addr == REG_STAT)
			begin
				if (reg_wdata[0] && !(in_valid && !take))
					st_next.overrun = 1'b0;
				if (reg_wdata[1] && !take)
					st_next.framing_err = 1'b0;
			end
		end
		// register reads, data valid one cycle later
		if (reg_read)
		begin
			if (reg_addr == REG_CTRL)
				st_next.rdata = st_reg.ctrl;
			else if (reg_addr == REG_STAT)
				st_next.rdata = {16'(st_reg.fill), 9'h000, 2'(st_reg.pkt),
					st_reg.store[0][DATA_W+1:DATA_W], ready_now,
					st_reg.framing_err, st_reg.overrun};
			else if (reg_addr == REG_BEAT)
				st_next.rdata = 32'(st_reg.store[0][DATA_W-1:0]);
			else
				st_next.rdata = {st_reg.packets, st_reg.beats};
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg      <= '0;
			st_reg.ctrl <= CTRL_RESET;
			st_reg.pkt  <= PKT_IDLE;
		end
		else if (clk_en)
			st_reg <= st_next;
	end

	assign reg_rdata = st_reg.rdata;
endmodule // stream_sink

// ==== verif/stream_checker.sv ====
`timescale 1ns/100ps
// ****
// sink checker
// ****
module stream_checker
	import stream_pkg::*;
#(
	parameter int DEPTH = DEPTH_DEF
)(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic        in_valid,
	input  wire logic        in_first,
	input  wire logic        in_last,
	input  wire logic        in_ready,
	input  wire logic [1:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	input  wire logic [31:0] reg_rdata
);
	logic [15:0] fill_reg, bts_reg, pks_reg;
	logic [1:0]  ctl_reg;
	logic        ovr_reg;
	wire take = in_valid && in_ready && clk_en;
	wire wctl = reg_write && clk_en && reg_addr == REG_CTRL;
	wire rs = reg_read && reg_addr == REG_STAT;
	// reference of what the sink took, refused and holds
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
		begin
			{fill_reg, bts_reg, pks_reg, ovr_reg} <= '0;
			ctl_reg <= 2'h3;
		end
		else if (clk_en)
		begin
			fill_reg <= fill_reg + 16'(take) - 16'(wctl && reg_wdata[2] && fill_reg != 0);
			bts_reg <= bts_reg + 16'(take);
			pks_reg <= pks_reg + 16'(take && in_last);
			ovr_reg <= (in_valid && !in_ready) || (ovr_reg && !(reg_write && rs == 0
				&& reg_addr == REG_STAT && reg_wdata[0]));
			ctl_reg <= wctl ? reg_wdata[1:0] : ctl_reg;
		end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	accept_off_a: assert property (wctl && !reg_wdata[0] |=> !in_ready)
		else $error("ready high with accept off");
	accept_on_a: assert property (wctl && reg_wdata[0] && fill_reg == 0 |=> in_ready)
		else $error("ready low with room");
	ready_full_a: assert property (fill_reg >= DEPTH |-> !in_ready)
		else $error("ready high when full");
	stat_ready_a: assert property (rs |=> reg_rdata[2] == $past(in_ready))
		else $error("ready status wrong");
	overrun_flag_a: assert property (rs |=> reg_rdata[0] == $past(ovr_reg))
		else $error("overrun flag wrong");
	fill_count_a: assert property (rs |=> reg_rdata[31:16] == $past(fill_reg))
		else $error("fill count wrong");
	count_beats_a: assert property (reg_read && reg_addr == REG_COUNT
		|=> reg_rdata == {$past(pks_reg), $past(bts_reg)})
		else $error("beat or packet count wrong");
	ctrl_read_a: assert property (reg_read && reg_addr == REG_CTRL
		|=> reg_rdata[1:0] == $past(ctl_reg))
		else $error("control readback wrong");
	cover property (take && in_first && in_last);
	cover property (in_valid && !in_ready);
	cover property (take && in_last);
endmodule // stream_checker

bind stream_sink stream_checker #(.DEPTH(DEPTH)) chk (.*);

// ==== verif/stream_source.sv ====
`timescale 1ns/100ps
// ****
// source model
// ****
module stream_source (
	input  wire logic        ref_clk,
	input  wire logic        in_ready,
	output logic             in_valid,
	output logic [31:0]      in_data,
	output logic             in_first,
	output logic             in_last,
	output logic [1:0]       in_empty
);
	// idle from time zero through reset
	initial {in_valid, in_data, in_first, in_last, in_empty} = '0;
	// hold one beat until taken or 40 cycles pass, called just after an edge
	task automatic send(input logic [31:0] d, input logic f, l, input logic [1:0] e,
		output bit ok);
		ok = 0;
		{in_valid, in_data, in_first, in_last, in_empty} <= {1'b1, d, f, l, e};
		repeat (40)
		begin
			@(negedge ref_clk);
			ok = in_ready;
			@(posedge ref_clk);
			if (ok)
				break;
		end
	endtask
	// released bus drops valid and markers, shows the inverse of the last data and empty
	task automatic idle();
		{in_valid, in_first, in_last} <= 3'h0;
		in_data <= ~in_data;
		in_empty <= ~in_empty;
	endtask
endmodule // stream_source

// ==== verif/streaming_packet_handshake_tb.sv ====
`timescale 1ns/100ps
module streaming_packet_handshake_tb
	import stream_pkg::*;
;
	logic        ref_clk, resetn, reg_write, reg_read, in_ready, clk_en;
	logic        in_valid, in_first, in_last;
	logic [1:0]  reg_addr, in_empty;
	logic [31:0] reg_wdata, reg_rdata, in_data;
	int          errors, checked;
	bit          ok;
	initial
	begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	stream_sink DUT (.*);
	stream_source src (.*);
	// ****
	// access tasks
	// ****
	task automatic end_of_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [31:0] m, e);
		@(posedge ref_clk);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(negedge ref_clk);
		checked++;
		if ((reg_rdata & m) !== e)
		begin
			errors++;
			$display("Error %0t: reg %0d got %h want %h", $time, a, reg_rdata & m, e);
		end
	endtask
	task automatic put(input logic [31:0] d, input logic f, l, input logic [1:0] e);
		src.send(d, f, l, e, ok);
		checked++;
		if (!ok)
		begin
			errors++;
			$display("Error %0t: beat not taken", $time);
			end_of_test();
		end
	endtask
	// ****
	// scenarios
	// ****
	initial
	begin
		{resetn, reg_write, reg_read, reg_addr, reg_wdata} = '0;
		clk_en = 1'b1;
		errors = 0;
		checked = 0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(REG_CTRL, '1, CTRL_RESET);
		wr(REG_CTRL, 32'h2);
		rd(REG_STAT, 32'h4, 32'h0);
		wr(REG_CTRL, 32'h3);
		@(posedge ref_clk);
		put(32'h1122_3344, 1'b1, 1'b0, 2'h3);
		put(32'hAABB_CCDD, 1'b0, 1'b1, 2'h3);
		put(32'h5566_7788, 1'b1, 1'b1, 2'h0);
		src.idle();
		rd(REG_STAT, 32'hFFFF_0003, 32'h0003_0000);
		rd(REG_COUNT, '1, 32'h0002_0003);
		rd(REG_BEAT, '1, 32'h1122_3344);
		wr(REG_CTRL, 32'h7);
		rd(REG_BEAT, '1, 32'hAA00_0000);
		wr(REG_CTRL, 32'h7);
		rd(REG_BEAT, '1, 32'h5566_7788);
		wr(REG_CTRL, 32'h7);
		@(posedge ref_clk);
		for (int i = 0; i < DEPTH_DEF; i++)
			put(32'(i), 1'b1, 1'b1, 2'h0);
		fork
			begin
				put(32'hFEED_0005, 1'b1, 1'b1, 2'h0);
				src.idle();
			end
			begin
				rd(REG_STAT, 32'hFFFF_0005, 32'h0004_0001);
				wr(REG_CTRL, 32'h7);
			end
		join
		repeat (DEPTH_DEF) wr(REG_CTRL, 32'h7);
		wr(REG_STAT, 32'h3);
		rd(REG_STAT, 32'hFFFF_0007, 32'h0000_0004);
		// first symbol in low bits, then a last beat with no packet open
		wr(REG_CTRL, 32'h1);
		@(posedge ref_clk);
		put(32'h1122_3344, 1'b1, 1'b1, 2'h3);
		put(32'h0000_00AA, 1'b0, 1'b1, 2'h0);
		src.idle();
		rd(REG_STAT, 32'hFFFF_0003, 32'h0002_0002);
		rd(REG_BEAT, '1, 32'h0000_0044);
		// a pop while the clock enable is low must not land
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(REG_CTRL, 32'h7);
		clk_en <= 1'b1;
		rd(REG_STAT, 32'hFFFF_0000, 32'h0002_0000);
		end_of_test();
	end
endmodule // streaming_packet_handshake_tb
